// File: logic/sub_exec_pkg.sv
package sub_exec_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPCODE = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_OPERAND = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [2:0] BANK_DREG = 3'b010;
  localparam logic [2:0] BANK_AREG = 3'b011;
  // flag positions
  localparam int FL_X = 4;
  localparam int FL_N = 3;
  localparam int FL_Z = 2;
  localparam int FL_V = 1;
  localparam int FL_C = 0;
  // status positions
  localparam int ST_DONE = 0;
  localparam int ST_ILLEGAL = 1;
  localparam int ST_MEMWR = 2;
  localparam int ST_MEMRD = 3;
  // instruction fields
  localparam int COND_HI = 11;
  localparam int COND_LO = 8;
  localparam logic [3:0] GRP_SCC = 4'h5;
  localparam logic [3:0] GRP_SUB = 4'h9;
  localparam logic [1:0] SCC_SIZE = 2'b11;
  localparam logic [1:0] OPM_ADDR = 2'b11;
  localparam logic [1:0] SZ_BYTE = 2'b00;
  localparam logic [1:0] SZ_WORD = 2'b01;
  localparam logic [1:0] SZ_LONG = 2'b10;
  // addressing modes
  localparam logic [2:0] MODE_DREG = 3'b000;
  localparam logic [2:0] MODE_AREG = 3'b001;
  localparam logic [2:0] MODE_MEMIND = 3'b010;
  localparam logic [2:0] MODE_EXT = 3'b111;
  localparam logic [2:0] EXT_ABSL = 3'b001;
  localparam logic [2:0] EXT_IMM = 3'b100;
  // values
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;
  localparam logic [7:0] BYTE_TRUE = 8'hFF;
  localparam logic [7:0] BYTE_FALSE = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: logic/set_cond_and_subtract_exec.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module set_cond_and_subtract_exec
  import sub_exec_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  if (ADDR_W < 8)
  begin : g_chk
    $error("address width too small for the register map");
  end

  logic awRdy_r, wRdy_r, bValid_r, arRdy_r, rValid_r;
  logic [ADDR_W-1:0] wAddr_r;
  logic [31:0] wData_r, rData_r;
  logic [3:0] wStrb_r;
  logic [1:0] bResp_r, rResp_r;
  logic cfgEarly_r;
  logic [31:0] operand_r, result_r;
  logic [4:0] flags_r;
  logic [3:0] status_r;
  logic [31:0] dReg_r [8];
  logic [31:0] aReg_r [8];
  logic [2:0] chkIdx_r;
  logic doWrite, exec;

  assign awready = awRdy_r;
  assign wready = wRdy_r;
  assign bvalid = bValid_r;
  assign bresp = bResp_r;
  assign arready = arRdy_r;
  assign rvalid = rValid_r;
  assign rdata = rData_r;
  assign rresp = rResp_r;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    // the 0x20 bank is a hole; only control words and the two register banks answer
    mapped = (a[ADDR_W-1:7] == '0) && (a[1:0] == 2'b00) &&
      (a[6:5] == BANK_DREG[1:0] || a[6:5] == BANK_AREG[1:0] ||
       (a[6:5] == 2'b00 && a[4:2] <= OFF_RESULT[4:2]));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  function automatic logic condTrue(input logic [3:0] cc, input logic [4:0] f);
    logic n, z, v, c;
    n = f[FL_N];
    z = f[FL_Z];
    v = f[FL_V];
    c = f[FL_C];
    unique case (cc)
      4'h0: condTrue = 1'b1;
      4'h1: condTrue = 1'b0;
      4'h2: condTrue = !c && !z;
      4'h3: condTrue = c || z;
      4'h4: condTrue = !c;
      4'h5: condTrue = c;
      4'h6: condTrue = !z;
      4'h7: condTrue = z;
      4'h8: condTrue = !v;
      4'h9: condTrue = v;
      4'hA: condTrue = !n;
      4'hB: condTrue = n;
      4'hC: condTrue = n == v;
      4'hD: condTrue = n != v;
      4'hE: condTrue = (n == v) && !z;
      4'hF: condTrue = z || (n != v);
    endcase
  endfunction

  // write channels may arrive in either order; commit once both are held
  assign doWrite = !awRdy_r && !wRdy_r && !bValid_r;
  assign exec = doWrite && (wAddr_r == OFF_OPCODE);

  always_ff @(posedge mclk)
    if (rst)
    begin
      awRdy_r <= 1'b1;
      wAddr_r <= '0;
    end
    else if (awvalid && awRdy_r)
    begin
      awRdy_r <= 1'b0;
      wAddr_r <= awaddr;
    end
    else if (doWrite)
      awRdy_r <= 1'b1;

  always_ff @(posedge mclk)
    if (rst)
    begin
      wRdy_r <= 1'b1;
      wData_r <= WORD_RST;
      wStrb_r <= 4'h0;
    end
    else if (wvalid && wRdy_r)
    begin
      wRdy_r <= 1'b0;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end
    else if (doWrite)
      wRdy_r <= 1'b1;

  always_ff @(posedge mclk)
    if (rst)
    begin
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end
    else if (doWrite)
    begin
      bValid_r <= 1'b1;
      bResp_r <= mapped(wAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bValid_r <= 1'b0;

  // instruction field split
  logic [15:0] op;
  logic [2:0] eaMode, eaReg, regSel, opm;
  logic isScc, isSub, isSuba, toEa, sccLegal, srcLegal, dstLegal, legal;
  logic [1:0] size;
  logic [31:0] dEa, dSel, eaVal, aDst, mask, minu, subt, res, aNew;
  logic [32:0] diff;
  logic sa, sb, sr, cTrue;
  logic [4:0] subFlags;

  always_comb
  begin
    op = wData_r[15:0];
    eaMode = op[5:3];
    eaReg = op[2:0];
    regSel = op[11:9];
    opm = op[8:6];
    dEa = dReg_r[eaReg];
    dSel = dReg_r[regSel];
    aDst = aReg_r[regSel];
    isScc = (op[15:12] == GRP_SCC) && (op[7:6] == SCC_SIZE);
    isSuba = (op[15:12] == GRP_SUB) && (opm[1:0] == OPM_ADDR);
    isSub = (op[15:12] == GRP_SUB) && !isSuba;
    toEa = opm[2];
    size = opm[1:0];
    cTrue = condTrue(op[COND_HI:COND_LO], flags_r);
    sccLegal = (eaMode != MODE_AREG) && (eaMode != MODE_EXT || eaReg <= EXT_ABSL);
    srcLegal = (eaMode == MODE_EXT) ? (eaReg <= EXT_IMM)
             : !(eaMode == MODE_AREG && size == SZ_BYTE && !isSuba);
    dstLegal = (eaMode == MODE_EXT) ? (eaReg <= EXT_ABSL) : (eaMode >= MODE_MEMIND);
    legal = (isScc && sccLegal) || (isSuba && srcLegal) ||
            (isSub && (toEa ? dstLegal : srcLegal));
    eaVal = (eaMode == MODE_DREG) ? dEa : (eaMode == MODE_AREG) ? aReg_r[eaReg] : operand_r;
    // memory operands come in through the operand register
    minu = toEa ? operand_r : dSel;
    subt = toEa ? dSel : eaVal;
    unique case (size)
      SZ_BYTE: mask = MASK_BYTE;
      SZ_WORD: mask = MASK_WORD;
      default: mask = MASK_LONG;
    endcase
    // masked zero-extended operands make bit 32 the borrow for every size
    diff = {1'b0, minu & mask} - {1'b0, subt & mask};
    res = diff[31:0] & mask;
    unique case (size)
      SZ_BYTE: {sa, sb, sr} = {minu[7], subt[7], res[7]};
      SZ_WORD: {sa, sb, sr} = {minu[15], subt[15], res[15]};
      default: {sa, sb, sr} = {minu[31], subt[31], res[31]};
    endcase
    subFlags[FL_C] = diff[32];
    subFlags[FL_X] = diff[32];
    subFlags[FL_N] = sr;
    subFlags[FL_Z] = (res == WORD_RST);
    subFlags[FL_V] = (sa != sb) && (sr != sa);
    aNew = aDst - (opm[2] ? eaVal : {{16{eaVal[15]}}, eaVal[15:0]});
  end

  always_ff @(posedge mclk)
    if (rst)
    begin
      cfgEarly_r <= 1'b0;
      operand_r <= WORD_RST;
    end
    else if (doWrite && wAddr_r == OFF_CFG)
      cfgEarly_r <= wStrb_r[0] ? wData_r[0] : cfgEarly_r;
    else if (doWrite && wAddr_r == OFF_OPERAND)
      operand_r <= merge(operand_r, wData_r, wStrb_r);

  // execution results; a bus write and an execute never share a cycle
  always_ff @(posedge mclk)
    if (rst)
    begin
      flags_r <= FLAGS_RST;
      status_r <= 4'h0;
      result_r <= WORD_RST;
      chkIdx_r <= 3'b000;
    end
    else if (exec)
    begin
      chkIdx_r <= isScc ? eaReg : regSel;
      status_r[ST_DONE] <= 1'b1;
      status_r[ST_ILLEGAL] <= !legal;
      status_r[ST_MEMWR] <= legal && ((isScc && eaMode != MODE_DREG) || (isSub && toEa));
      status_r[ST_MEMRD] <= legal && ((isScc && eaMode != MODE_DREG && cfgEarly_r) ||
                                      (isSub && toEa));
      if (legal && isScc)
        result_r <= {24'h00_0000, cTrue ? BYTE_TRUE : BYTE_FALSE};
      else if (legal && isSub)
        result_r <= res;
      if (legal && isSub)
        flags_r <= subFlags; // flags untouched otherwise
    end
    else if (doWrite && wAddr_r == OFF_FLAGS && wStrb_r[0])
      flags_r <= wData_r[4:0];

  always_ff @(posedge mclk)
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        dReg_r[i] <= WORD_RST;
        aReg_r[i] <= WORD_RST;
      end
    end
    else if (exec && legal)
    begin
      if (isScc && eaMode == MODE_DREG)
        dReg_r[eaReg][7:0] <= cTrue ? BYTE_TRUE : BYTE_FALSE;
      else if (isSub && !toEa)
        dReg_r[regSel] <= (dSel & ~mask) | res;
      else if (isSuba)
        aReg_r[regSel] <= aNew;
    end
    else if (doWrite && wAddr_r[6:5] == BANK_DREG[1:0] && wAddr_r[ADDR_W-1:7] == '0)
      dReg_r[wAddr_r[4:2]] <= merge(dReg_r[wAddr_r[4:2]], wData_r, wStrb_r);
    else if (doWrite && wAddr_r[6:5] == BANK_AREG[1:0] && wAddr_r[ADDR_W-1:7] == '0)
      aReg_r[wAddr_r[4:2]] <= merge(aReg_r[wAddr_r[4:2]], wData_r, wStrb_r);

  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = WORD_RST;
    if (araddr[6:5] == BANK_DREG[1:0])
      rdMux = dReg_r[araddr[4:2]];
    else if (araddr[6:5] == BANK_AREG[1:0])
      rdMux = aReg_r[araddr[4:2]];
    else
      unique case (araddr[4:2])
        OFF_CFG[4:2]: rdMux = {31'h0, cfgEarly_r};
        OFF_OPERAND[4:2]: rdMux = operand_r;
        OFF_FLAGS[4:2]: rdMux = {27'h0, flags_r};
        OFF_STATUS[4:2]: rdMux = {28'h0, status_r};
        OFF_RESULT[4:2]: rdMux = result_r;
        default: rdMux = WORD_RST;
      endcase
  end

  always_ff @(posedge mclk)
    if (rst)
    begin
      arRdy_r <= 1'b1;
      rValid_r <= 1'b0;
      rData_r <= WORD_RST;
      rResp_r <= RESP_OKAY;
    end
    else if (arvalid && arRdy_r)
    begin
      arRdy_r <= 1'b0;
      rValid_r <= 1'b1;
      rData_r <= mapped(araddr) ? rdMux : WORD_RST;
      rResp_r <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValid_r && rready)
    begin
      rValid_r <= 1'b0;
      arRdy_r <= 1'b1;
    end

  // checks
  sequence s_sccToD;
    exec && isScc && eaMode == MODE_DREG;
  endsequence
  sequence s_subLegal;
    exec && isSub && legal;
  endsequence

  property p_sccValue;
    @(posedge mclk) disable iff (rst)
    s_sccToD ##0 cTrue |=> dReg_r[chkIdx_r][7:0] == BYTE_TRUE && status_r == 4'h1;
  endproperty
  a_sccValue: assert property (p_sccValue) else $error("true condition not stored as FF");

  property p_sccFalse;
    @(posedge mclk) disable iff (rst)
    s_sccToD ##0 op[COND_HI:COND_LO] == 4'h1 |=> dReg_r[chkIdx_r] == {$past(dEa[31:8]), 8'h00};
  endproperty
  a_sccFalse: assert property (p_sccFalse) else $error("never-true test did not clear byte");

  property p_flagsKept;
    @(posedge mclk) disable iff (rst)
    exec && (isScc || isSuba) |=> $stable(flags_r) ##1 $stable(flags_r);
  endproperty
  a_flagsKept: assert property (p_flagsKept) else $error("flags changed by a non-flag op");

  property p_sccAreg;
    @(posedge mclk) disable iff (rst)
    exec && isScc && eaMode == MODE_AREG |=> status_r[ST_ILLEGAL] && !status_r[ST_MEMWR];
  endproperty
  a_sccAreg: assert property (p_sccAreg) else $error("address register destination accepted");

  property p_readFirst;
    @(posedge mclk) disable iff (rst)
    exec && isScc && legal && eaMode != MODE_DREG |=> status_r[ST_MEMRD] == $past(cfgEarly_r);
  endproperty
  a_readFirst: assert property (p_readFirst) else $error("read-before-write flag wrong");

  property p_subToEa;
    @(posedge mclk) disable iff (rst)
    s_subLegal ##0 toEa && size == SZ_LONG |=> result_r == $past(operand_r) - $past(dSel);
  endproperty
  a_subToEa: assert property (p_subToEa) else $error("ea minus register wrong");

  property p_byteAreg;
    @(posedge mclk) disable iff (rst)
    exec && isSub && !toEa && size == SZ_BYTE && eaMode == MODE_AREG |=> status_r[ST_ILLEGAL];
  endproperty
  a_byteAreg: assert property (p_byteAreg) else $error("byte address register source accepted");

  property p_dstMode;
    @(posedge mclk) disable iff (rst)
    exec && isSub && toEa && eaMode < MODE_MEMIND |=> status_r[ST_ILLEGAL] && $stable(flags_r);
  endproperty
  a_dstMode: assert property (p_dstMode) else $error("register ea destination accepted");

  property p_extend;
    @(posedge mclk) disable iff (rst)
    s_subLegal |=> flags_r[FL_X] == flags_r[FL_C] && flags_r[FL_Z] == (result_r == WORD_RST);
  endproperty
  a_extend: assert property (p_extend) else $error("extend or zero flag mismatch");

  property p_subaWord;
    @(posedge mclk) disable iff (rst)
    exec && isSuba && legal && !opm[2] |=>
      aReg_r[chkIdx_r] == $past(aDst) - {{16{$past(eaVal[15])}}, $past(eaVal[15:0])};
  endproperty
  a_subaWord: assert property (p_subaWord) else $error("word address subtract wrong");

endmodule

// File: sim/operand_memory.sv
`timescale 1ns/1ps
// instruction stream and operand memory on the far side of the block
module operand_memory
  import sub_exec_pkg::*;
;
  logic [31:0] mem [0:15];

  // distinct filler so stale reads never look like fresh results
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = 32'h5A00_0000 | i;
  end

  task automatic store(input logic [3:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask

  function automatic logic [31:0] load(input logic [3:0] a);
    return mem[a];
  endfunction

  // software fix-up turning ff/00 into 1/0
  task automatic negate_byte(input logic [3:0] a);
    mem[a][7:0] = 8'h00 - mem[a][7:0];
  endtask

  // data register destination only through register opmodes
  function automatic logic [15:0] dreg_dest_op(input logic [2:0] r, input logic [1:0] sz,
                                               input logic [5:0] ea);
    return {GRP_SUB, r, 1'b0, sz, ea};
  endfunction
endmodule

// File: sim/set_cond_and_subtract_exec_test.sv
`timescale 1ns/1ps
module set_cond_and_subtract_exec_test;
  import sub_exec_pkg::*;
  // clock and reset
  logic mclk = 1'b0;
  logic rst = 1'b1;
  // bus
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int failures = 0;
  int checks = 0;

  always #5 mclk = ~mclk;

  set_cond_and_subtract_exec #(.ADDR_W(8)) dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  operand_memory mem_u ();

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entry waits an edge so a strobe is never assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) failures++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) failures++;
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
  endtask

  task automatic exec(input logic [15:0] op);
    put(OFF_OPCODE, {16'h0000, op});
  endtask

  function automatic logic [7:0] dreg(input logic [2:0] n);
    return {BANK_DREG, n, 2'b00};
  endfunction

  function automatic logic [7:0] areg(input logic [2:0] n);
    return {BANK_AREG, n, 2'b00};
  endfunction

  function automatic logic [31:0] stat(input logic i, input logic w, input logic m);
    stat = 32'h0000_0000;
    stat[ST_DONE] = 1'b1;
    stat[ST_ILLEGAL] = i;
    stat[ST_MEMWR] = w;
    stat[ST_MEMRD] = m;
  endfunction

  function automatic logic cond_true(input logic [3:0] c, input logic [4:0] f);
    logic n, z, v, cy;
    {n, z, v, cy} = f[3:0];
    case (c)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !cy && !z;
      4'h3: return cy || z;
      4'h4: return !cy;
      4'h5: return cy;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'hA: return !n;
      4'hB: return n;
      4'hC: return n == v;
      4'hD: return n != v;
      4'hE: return !z && (n == v);
      default: return z || (n != v);
    endcase
  endfunction

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h3C, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h3C, 32'h1234_5678, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_scc_cond();
    logic [4:0] fs [2] = '{5'h0B, 5'h04};
    logic [31:0] d;
    for (int k = 0; k < 2; k++)
      for (int c = 0; c < 16; c++)
      begin
        put(OFF_FLAGS, {27'h0, fs[k]});
        put(dreg(1), 32'hA5A5_A5A5);
        exec({GRP_SCC, 4'(c), SCC_SIZE, MODE_DREG, 3'd1});
        get(dreg(1), d);
        check(d, {24'hA5_A5A5, cond_true(4'(c), fs[k]) ? BYTE_TRUE : BYTE_FALSE});
        get(OFF_FLAGS, d);
        check(d, {27'h0, fs[k]});
      end
  endtask

  task automatic t_scc_mem();
    logic [5:0] bad [3] = '{{MODE_AREG, 3'd0}, {MODE_EXT, EXT_IMM}, {MODE_EXT, 3'b010}};
    logic [31:0] d;
    put(OFF_FLAGS, 32'h0000_0000);
    for (int cfg = 0; cfg < 2; cfg++)
    begin
      put(OFF_CFG, 32'(cfg));
      exec({GRP_SCC, 4'h6, SCC_SIZE, MODE_MEMIND, 3'd2});
      get(OFF_STATUS, d);
      check(d, stat(1'b0, 1'b1, 1'(cfg)));
      get(OFF_RESULT, d);
      check(d, {24'h00_0000, BYTE_TRUE});
      mem_u.store(4'd1, d);
      mem_u.negate_byte(4'd1);
      check(mem_u.load(4'd1), 32'h0000_0001);
    end
    for (int k = 0; k < 3; k++)
    begin
      exec({GRP_SCC, 4'h0, SCC_SIZE, bad[k]});
      get(OFF_STATUS, d);
      check(d, stat(1'b1, 1'b0, 1'b0));
    end
  endtask

  task automatic t_sub_reg();
    logic [1:0] sz [3] = '{SZ_BYTE, SZ_WORD, SZ_LONG};
    logic [31:0] dv [3] = '{32'h1234_5600, 32'h1234_8000, 32'h0000_0005};
    logic [31:0] sv [3] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0005};
    logic [31:0] ev [3] = '{32'h1234_56FF, 32'h1234_7FFF, 32'h0000_0000};
    logic [4:0] fv [3] = '{5'h19, 5'h02, 5'h04};
    logic [31:0] d;
    for (int k = 0; k < 3; k++)
    begin
      put(OFF_FLAGS, 32'h0000_001F);
      put(dreg(2), dv[k]);
      put(OFF_OPERAND, sv[k]);
      exec(mem_u.dreg_dest_op(3'd2, sz[k], {MODE_EXT, EXT_IMM}));
      get(dreg(2), d);
      check(d, ev[k]);
      get(OFF_FLAGS, d);
      check(d, {27'h0, fv[k]});
      get(OFF_STATUS, d);
      check(d, stat(1'b0, 1'b0, 1'b0));
    end
  endtask

  task automatic t_sub_mem();
    logic [31:0] d;
    put(dreg(3), 32'h0000_0003);
    put(OFF_OPERAND, 32'h0000_0010);
    exec({GRP_SUB, 3'd3, 3'b110, MODE_MEMIND, 3'd0});
    get(OFF_RESULT, d);
    check(d, 32'h0000_000D);
    mem_u.store(4'd0, d);
    get(OFF_STATUS, d);
    check(d, stat(1'b0, 1'b1, 1'b1));
    get(OFF_FLAGS, d);
    check(d, 32'h0000_0000);
    put(OFF_OPERAND, 32'h0000_0000);
    exec({GRP_SUB, 3'd3, 3'b100, MODE_EXT, EXT_ABSL});
    get(OFF_RESULT, d);
    check(d, 32'h0000_00FD);
    get(OFF_FLAGS, d);
    check(d, 32'h0000_0019);
  endtask

  task automatic t_sub_illegal();
    logic [15:0] ops [5] = '{{GRP_SUB, 3'd1, 3'b000, MODE_AREG, 3'd0},
      {GRP_SUB, 3'd1, 3'b101, MODE_DREG, 3'd0}, {GRP_SUB, 3'd1, 3'b110, MODE_AREG, 3'd0},
      {GRP_SUB, 3'd1, 3'b101, MODE_EXT, EXT_IMM}, {GRP_SUB, 3'd1, 3'b110, MODE_EXT, 3'b010}};
    logic [31:0] d;
    put(OFF_FLAGS, 32'h0000_000A);
    put(dreg(1), 32'hCAFE_0001);
    for (int k = 0; k < 5; k++)
    begin
      exec(ops[k]);
      get(OFF_STATUS, d);
      check(d, stat(1'b1, 1'b0, 1'b0));
      get(dreg(1), d);
      check(d, 32'hCAFE_0001);
      get(OFF_FLAGS, d);
      check(d, 32'h0000_000A);
    end
  endtask

  task automatic t_subtract_address_op();
    logic [31:0] d;
    put(OFF_FLAGS, 32'h0000_0015);
    put(areg(2), 32'h0000_0055);
    put(areg(3), 32'h0000_0010);
    put(OFF_OPERAND, 32'h0000_FFFF);
    // word source is sign extended, so minus one adds one
    exec({GRP_SUB, 3'd3, 3'b011, MODE_EXT, EXT_IMM});
    get(areg(3), d);
    check(d, 32'h0000_0011);
    get(areg(2), d);
    check(d, 32'h0000_0055);
    put(OFF_OPERAND, 32'h8000_0011);
    exec({GRP_SUB, 3'd3, 3'b111, MODE_EXT, EXT_IMM});
    get(areg(3), d);
    check(d, 32'h8000_0000);
    get(OFF_FLAGS, d);
    check(d, 32'h0000_0015);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_bus();
    t_scc_cond();
    t_scc_mem();
    t_sub_reg();
    t_sub_mem();
    t_sub_illegal();
    t_subtract_address_op();
    complete_run();
  end

  // generous bound, the full run needs well under a tenth of it
  initial
  begin
    #500000;
    failures++;
    complete_run();
  end
endmodule
